// >>> rtl/async_serial_tx_rx_core.sv
`timescale 1ns/100ps
`include "serial_core_defs.svh"
module async_serial_tx_rx_core
   import serial_core_pkg::*;
#(
   parameter int BIT_TICKS = `BIT_TICKS_DEF
) (
   input wire logic CLK_IN, // 100 MHz clock
   input wire logic RST_IN, // Sync reset, high
   input wire logic [7:0] SERIAL_MODE_REG_IN, // Mode control
   input wire logic [7:0] BAUD_DIVIDER_REG_IN, // Ticks minus one
   input wire logic TX_WRITE_IN, // Write strobe
   input wire logic [7:0] TX_DATA_IN, // Character to send
   input wire logic TX_FLAG_CLR_IN, // Clear done flag
   input wire logic RX_BUF_READ_IN, // Buffer read strobe
   input wire logic SERIAL_IN_PIN_IN, // Serial input line
   input wire logic EXT_CLK_SEL_IN, // External bit clock
   input wire logic LOW_POWER_IN, // Stop or idle mode
   output logic SERIAL_OUT_PIN_OUT, // Serial output line
   output logic SERIAL_OUT_OE_OUT, // Output driven
   output logic TX_BUSY_OUT, // Transmit in progress
   output logic TX_DONE_IRQ_OUT, // Transmit done pulse
   output logic TX_DONE_PENDING_FLAG_OUT, // Sticky done flag
   output logic [7:0] RX_BUFFER_REG_OUT, // Received character
   output logic [7:0] RX_ERROR_STATUS_REG_OUT, // Error codes
   output logic RX_DONE_IRQ_OUT, // Receive done pulse
   output logic RX_ERROR_IRQ_OUT, // Receive error pulse
   output logic RX_BUSY_OUT // Frame in progress
);

   localparam int HALF_TICKS = BIT_TICKS / 2;

   initial begin
      if (BIT_TICKS < 4 || BIT_TICKS > 32) begin
         $error("BIT_TICKS must be 4 to 32");
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic par_calc(input logic [7:0] d, input logic c8,
                                     input logic odd);
      logic ones;
      ones = ^{(c8 & d[7]), d[6:0]};
      return odd ? ~ones : ones;
   endfunction : par_calc

   function automatic logic [4:0] ph_inc(input logic [4:0] p);
      return 5'(p + 5'h01);
   endfunction : ph_inc

   // ----------------------------------------
   // Mode decode and clock gating
   // ----------------------------------------
   logic tx_en;
   logic rx_en;
   logic char8;
   logic stop2;
   logic isrm;
   parity_e par_mode;
   logic par_on;
   logic [3:0] nchar;
   logic run;
   logic hold;

   assign tx_en = SERIAL_MODE_REG_IN[`MODE_TXE];
   assign rx_en = SERIAL_MODE_REG_IN[`MODE_RXE];
   assign char8 = SERIAL_MODE_REG_IN[`MODE_CL8];
   assign stop2 = SERIAL_MODE_REG_IN[`MODE_SL2];
   assign isrm = SERIAL_MODE_REG_IN[`MODE_ISRM];
   assign par_mode = parity_e'(SERIAL_MODE_REG_IN[`MODE_PAR_HI:`MODE_PAR_LO]);
   assign par_on = (par_mode != PAR_NONE);
   assign nchar = char8 ? `CHAR_BITS_8 : `CHAR_BITS_7;
   assign run = ~(LOW_POWER_IN & ~EXT_CLK_SEL_IN);
   assign hold = LOW_POWER_IN;

   // ----------------------------------------
   // Baud divider
   // ----------------------------------------
   logic [7:0] div_q;
   logic tick;

   assign tick = run && (div_q == BAUD_DIVIDER_REG_IN);

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         div_q <= 8'h00;
      end else if (run) begin
         div_q <= tick ? 8'h00 : 8'(div_q + 8'h01);
      end
   end

   // ----------------------------------------
   // Transmitter
   // ----------------------------------------
   logic [11:0] tx_frame_q;
   logic [3:0] tx_left_q;
   logic [4:0] tx_ph_q;
   logic tx_busy_q;
   logic tx_out_q;
   logic tx_go;
   logic tx_bit_end;
   logic tx_fin;
   logic [11:0] frame_d;
   logic [3:0] flen_d;

   assign tx_go = run && TX_WRITE_IN && tx_en && !tx_busy_q;
   assign tx_bit_end = tick && tx_busy_q && (tx_ph_q == 5'(BIT_TICKS - 1));
   assign tx_fin = tx_bit_end && (tx_left_q == 4'h0);

   always_comb begin
      frame_d = '1;
      frame_d[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(nchar)) begin
            frame_d[i + 1] = TX_DATA_IN[i];
         end
      end
      if (par_on) begin
         frame_d[nchar + 4'h1] = (par_mode == PAR_ZERO) ? 1'b0 :
            par_calc(TX_DATA_IN, char8, par_mode == PAR_ODD);
      end
      flen_d = 4'(nchar + 4'h2 + {3'h0, par_on} + {3'h0, stop2});
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         tx_busy_q <= 1'b0;
         tx_out_q <= 1'b1;
         tx_frame_q <= '1;
         tx_left_q <= 4'h0;
         tx_ph_q <= 5'h00;
      end else if (run) begin
         if (!tx_en) begin
            tx_busy_q <= 1'b0;
            tx_out_q <= 1'b1;
         end else if (tx_go) begin
            tx_busy_q <= 1'b1;
            tx_out_q <= frame_d[0];
            tx_frame_q <= {1'b1, frame_d[11:1]};
            tx_left_q <= 4'(flen_d - 4'h1);
            tx_ph_q <= 5'h00;
         end else if (tx_busy_q && tick) begin
            tx_ph_q <= tx_bit_end ? 5'h00 : ph_inc(tx_ph_q);
            if (tx_fin) begin
               tx_busy_q <= 1'b0;
               tx_out_q <= 1'b1;
            end else if (tx_bit_end) begin
               tx_out_q <= tx_frame_q[0];
               tx_frame_q <= {1'b1, tx_frame_q[11:1]};
               tx_left_q <= 4'(tx_left_q - 4'h1);
            end
         end
      end
   end

   assign SERIAL_OUT_PIN_OUT = tx_out_q;
   assign SERIAL_OUT_OE_OUT = tx_en;
   assign TX_BUSY_OUT = tx_busy_q;

   // ----------------------------------------
   // Receiver
   // ----------------------------------------
   rx_state_e rx_st_q;
   logic [4:0] rx_ph_q;
   logic [3:0] rx_idx_q;
   logic [8:0] rx_sh_q;
   logic [3:0] nbits_rx;
   logic rx_bit_end;
   logic rx_fin;
   logic [7:0] rx_data;
   logic rx_pbit;
   logic par_err;
   logic [7:0] err_d;
   logic unread_q;

   assign nbits_rx = 4'(nchar + {3'h0, par_on});
   assign rx_bit_end = tick && (rx_ph_q == 5'(BIT_TICKS - 1));
   assign rx_fin = run && rx_en && (rx_st_q == RX_STOP) && rx_bit_end;
   assign rx_data = {char8 & rx_sh_q[7], rx_sh_q[6:0]};
   assign rx_pbit = rx_sh_q[nchar];
   assign par_err = ((par_mode == PAR_ODD) || (par_mode == PAR_EVEN)) &&
      (par_calc(rx_data, char8, par_mode == PAR_ODD) != rx_pbit);
   assign err_d = (unread_q ? `ERR_OVR : `ERR_NONE) |
      (SERIAL_IN_PIN_IN ? `ERR_NONE : `ERR_FRM) |
      (par_err ? `ERR_PAR : `ERR_NONE);

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rx_st_q <= RX_IDLE;
         rx_ph_q <= 5'h00;
         rx_idx_q <= 4'h0;
         rx_sh_q <= 9'h000;
      end else if (run) begin
         if (!rx_en) begin
            rx_st_q <= RX_IDLE;
         end else if (tick) begin
            case (rx_st_q)
               RX_IDLE: begin
                  if (!SERIAL_IN_PIN_IN) begin
                     rx_st_q <= RX_START;
                     rx_ph_q <= 5'h00;
                  end
               end
               RX_START: begin
                  rx_ph_q <= ph_inc(rx_ph_q);
                  if (rx_ph_q == 5'(HALF_TICKS - 1)) begin
                     rx_st_q <= SERIAL_IN_PIN_IN ? RX_IDLE : RX_DATA;
                     rx_ph_q <= 5'h00;
                     rx_idx_q <= 4'h0;
                  end
               end
               RX_DATA: begin
                  rx_ph_q <= rx_bit_end ? 5'h00 : ph_inc(rx_ph_q);
                  if (rx_bit_end) begin
                     rx_sh_q[rx_idx_q] <= SERIAL_IN_PIN_IN;
                     rx_idx_q <= 4'(rx_idx_q + 4'h1);
                     if (rx_idx_q == 4'(nbits_rx - 4'h1)) begin
                        rx_st_q <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  rx_ph_q <= rx_bit_end ? 5'h00 : ph_inc(rx_ph_q);
                  if (rx_bit_end) begin
                     rx_st_q <= RX_IDLE;
                  end
               end
               default: begin
                  rx_st_q <= RX_IDLE;
               end
            endcase
         end
      end
   end

   assign RX_BUSY_OUT = (rx_st_q != RX_IDLE);

   // ----------------------------------------
   // Receive buffer and status
   // ----------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         RX_BUFFER_REG_OUT <= 8'h00;
      end else if (rx_fin) begin
         RX_BUFFER_REG_OUT <= rx_data;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         RX_ERROR_STATUS_REG_OUT <= `ERR_NONE;
      end else if (rx_fin) begin
         RX_ERROR_STATUS_REG_OUT <= err_d;
      end else if (RX_BUF_READ_IN) begin
         RX_ERROR_STATUS_REG_OUT <= `ERR_NONE;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         unread_q <= 1'b0;
      end else if (rx_fin) begin
         unread_q <= 1'b1;
      end else if (RX_BUF_READ_IN) begin
         unread_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Interrupt requests
   // ----------------------------------------
   logic rxe_raw;
   logic rxd_due_q;
   logic tx_pend_q;
   logic rxe_pend_q;
   logic rxd_pend_q;
   logic tx_any;
   logic rxe_any;
   logic rxd_any;

   assign rxe_raw = rx_fin && (err_d != `ERR_NONE);
   assign tx_any = tx_pend_q | (run & tx_fin);
   assign rxe_any = rxe_pend_q | rxe_raw;
   assign rxd_any = rxd_pend_q | rxd_due_q;

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         rxd_due_q <= 1'b0;
      end else begin
         rxd_due_q <= rx_fin && ((err_d == `ERR_NONE) || !isrm);
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         tx_pend_q <= 1'b0;
         rxe_pend_q <= 1'b0;
         rxd_pend_q <= 1'b0;
         TX_DONE_IRQ_OUT <= 1'b0;
         RX_ERROR_IRQ_OUT <= 1'b0;
         RX_DONE_IRQ_OUT <= 1'b0;
      end else begin
         tx_pend_q <= tx_any & hold;
         rxe_pend_q <= rxe_any & hold;
         rxd_pend_q <= rxd_any & (hold | rxe_pend_q);
         TX_DONE_IRQ_OUT <= tx_any & ~hold;
         RX_ERROR_IRQ_OUT <= rxe_any & ~hold;
         RX_DONE_IRQ_OUT <= rxd_any & ~hold & ~rxe_pend_q;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         TX_DONE_PENDING_FLAG_OUT <= 1'b0;
      end else if (run && tx_fin) begin
         TX_DONE_PENDING_FLAG_OUT <= 1'b1;
      end else if (TX_FLAG_CLR_IN) begin
         TX_DONE_PENDING_FLAG_OUT <= 1'b0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_odd_err;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && par_mode == PAR_ODD && !(^{rx_data, rx_pbit})
         |=> RX_ERROR_STATUS_REG_OUT[2];
   endproperty
   a_odd_err: assert property (p_odd_err) else $error("odd parity miss");

   property p_zero_par;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && par_mode == PAR_ZERO |=> !RX_ERROR_STATUS_REG_OUT[2];
   endproperty
   a_zero_par: assert property (p_zero_par) else $error("zero parity flagged");

   property p_no_par;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && par_mode == PAR_NONE |=> !RX_ERROR_STATUS_REG_OUT[2];
   endproperty
   a_no_par: assert property (p_no_par) else $error("no parity flagged");

   property p_even_err;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && par_mode == PAR_EVEN && (^{rx_data, rx_pbit})
         |=> RX_ERROR_STATUS_REG_OUT[2];
   endproperty
   a_even_err: assert property (p_even_err) else $error("even parity miss");

   property p_start_bit;
      @(posedge CLK_IN) disable iff (RST_IN)
      tx_go |=> !SERIAL_OUT_PIN_OUT && TX_BUSY_OUT;
   endproperty
   a_start_bit: assert property (p_start_bit) else $error("no start bit");

   property p_idle_high;
      @(posedge CLK_IN) disable iff (RST_IN)
      tx_en && !tx_busy_q |-> SERIAL_OUT_PIN_OUT && SERIAL_OUT_OE_OUT;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("idle not high");

   property p_tx_irq;
      @(posedge CLK_IN) disable iff (RST_IN)
      run && tx_fin && !LOW_POWER_IN |=> TX_DONE_IRQ_OUT && !TX_BUSY_OUT;
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("tx done missing");

   property p_buf_copy;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin |=> RX_BUFFER_REG_OUT == $past(rx_data);
   endproperty
   a_buf_copy: assert property (p_buf_copy) else $error("buffer not loaded");

   property p_err_first;
      @(posedge CLK_IN) disable iff (RST_IN)
      rxe_raw && !isrm && !LOW_POWER_IN ##1 !LOW_POWER_IN
         |-> RX_ERROR_IRQ_OUT && !RX_DONE_IRQ_OUT ##1 RX_DONE_IRQ_OUT;
   endproperty
   a_err_first: assert property (p_err_first) else $error("irq order wrong");

   property p_overrun;
      @(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && unread_q |=> RX_ERROR_STATUS_REG_OUT[0];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_abort;
      @(posedge CLK_IN) disable iff (RST_IN)
      run && !rx_en |=> rx_st_q == RX_IDLE && $stable(RX_BUFFER_REG_OUT);
   endproperty
   a_abort: assert property (p_abort) else $error("abort failed");

   property p_freeze;
      @(posedge CLK_IN) disable iff (RST_IN)
      !run |=> $stable(tx_out_q) && $stable(rx_ph_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("not frozen");

   c_tx_done: cover property (@(posedge CLK_IN) disable iff (RST_IN) TX_DONE_IRQ_OUT);
   c_rx_ok: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      rx_fin && err_d == `ERR_NONE);
   c_rx_err: cover property (@(posedge CLK_IN) disable iff (RST_IN) RX_ERROR_IRQ_OUT);
   c_held: cover property (@(posedge CLK_IN) disable iff (RST_IN)
      rxe_pend_q ##1 RX_ERROR_IRQ_OUT);

endmodule : async_serial_tx_rx_core

// >>> rtl/serial_core_defs.svh
`ifndef SERIAL_CORE_DEFS_SVH
`define SERIAL_CORE_DEFS_SVH
// Overview of operation
// - Odd parity: receive error when ones in character plus parity are even.
// - Zero parity: send parity 0, never check it on receive.
// - No parity: no parity bit sent or expected, no parity error.
// - Character write starts transmit; start, parity, stop bits added.
// - Transmit done interrupt once shift register has emptied.
// - Mode bit 7 enables transmit and drives line idle high.
// - Receive enable samples input on the baud divider bit clock.
// - Low input starts counter; half bit later re-sample confirms start.
// - Frame ends after one stop bit, even with two stop bits set.
// - Completion copies character to receive buffer, raises receive done.
// - Errored frame still buffered; done suppressed when mode bit 1 set.
// - Receive disable aborts at once; buffer, status, interrupts unchanged.
// - Frame completing before buffer read sets overrun code 01h.
// - Parity mismatch sets parity error code 04h.
// - Missing stop bit sets framing error flag.
// - Receive error interrupt comes before receive done of that frame.
// - Status clears on buffer read or next frame; new errors set.
// - Internal clock stopped freezes baud, transmit and receive state and the output level.
// - External clock in low power keeps working; interrupts held pending.
// - Frame: start, 7 or 8 bits, optional parity, 1 or 2 stops.
// - 7-bit mode: transmit ignores bit 7, receive returns bit 7 zero.
// - Even parity: parity makes ones even; odd count is an error.

// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define MODE_TXE 7
`define MODE_RXE 6
`define MODE_PAR_HI 5
`define MODE_PAR_LO 4
`define MODE_CL8 3
`define MODE_SL2 2
`define MODE_ISRM 1

// ----------------------------------------
// Error status codes and timing
// ----------------------------------------
`define ERR_OVR 8'h01
`define ERR_FRM 8'h02
`define ERR_PAR 8'h04
`define ERR_NONE 8'h00
`define BIT_TICKS_DEF 16
`define CHAR_BITS_7 4'h7
`define CHAR_BITS_8 4'h8
`endif

// >>> rtl/serial_core_pkg.sv
package serial_core_pkg;
   typedef enum logic [1:0] {
      PAR_NONE = 2'h0,
      PAR_ZERO = 2'h1,
      PAR_ODD = 2'h2,
      PAR_EVEN = 2'h3
   } parity_e;
   typedef enum logic [3:0] {
      RX_IDLE = 4'h1,
      RX_START = 4'h2,
      RX_DATA = 4'h4,
      RX_STOP = 4'h8
   } rx_state_e;
endpackage : serial_core_pkg

// >>> tb/serial_station.sv
`timescale 1ns/100ps
module serial_station
   import serial_core_pkg::*;
#(
   parameter int BT = 8
) (
   input wire logic clk_in, // Bench clock
   input wire logic line_in, // Line from device
   input wire logic [7:0] mode_in, // Frame format
   output logic line_out, // Line to device
   output logic got_out, // Character decoded
   output logic [7:0] got_data_out, // Decoded character
   output logic got_ok_out // Framing and parity right
);
   function automatic logic par_of(input logic [7:0] d, input logic [1:0] m);
      return (m == PAR_ZERO) ? 1'b0 : (^d ^ (m == PAR_ODD));
   endfunction : par_of
   task automatic bit_out(input logic v, input int c);
      line_out = v;
      repeat (c) @(posedge clk_in);
      #1;
   endtask : bit_out
   // ----------------------------------------
   // Sending side
   // ----------------------------------------
   task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
      int n;
      n = mode_in[3] ? 8 : 7;
      bit_out(1'b0, BT);
      for (int i = 0; i < n; i++) begin
         bit_out(d[i], BT);
      end
      if (mode_in[5:4] != PAR_NONE) begin
         bit_out(par_of(d & {mode_in[3], 7'h7f}, mode_in[5:4]) ^ bad_par, BT);
      end
      // Bad stop ends early so no false start follows
      bit_out(!bad_stop, bad_stop ? BT * 3 / 4 : BT);
      bit_out(1'b1, BT);
   endtask : send
   initial begin
      line_out = 1'b1;
      got_out = 1'b0;
      got_data_out = 8'h00;
      got_ok_out = 1'b0;
   end
   // ----------------------------------------
   // Receiving side
   // ----------------------------------------
   always begin : decode
      int n;
      @(negedge line_in);
      n = mode_in[3] ? 8 : 7;
      repeat (BT / 2) @(posedge clk_in);
      #1;
      got_ok_out = (line_in === 1'b0);
      got_data_out = 8'h00;
      for (int i = 0; i < n; i++) begin
         repeat (BT) @(posedge clk_in);
         #1;
         got_data_out[i] = line_in;
      end
      if (mode_in[5:4] != PAR_NONE) begin
         repeat (BT) @(posedge clk_in);
         #1;
         got_ok_out &= (line_in === par_of(got_data_out, mode_in[5:4]));
      end
      repeat (mode_in[2] ? 2 : 1) begin
         repeat (BT) @(posedge clk_in);
         #1;
         got_ok_out &= (line_in === 1'b1);
      end
      got_out = 1'b1;
      @(posedge clk_in);
      #1;
      got_out = 1'b0;
   end
endmodule : serial_station

// >>> tb/testbench.sv
`timescale 1ns/100ps
`include "serial_core_defs.svh"
module testbench;
   import serial_core_pkg::*;
   localparam int BT = 8;
   typedef struct packed {logic [7:0] d; logic [7:0] st; logic isrm;} note_s;
   logic clk, rst, tx_write, flag_clr, buf_read, ext_sel, low_pw, got, got_ok;
   logic [7:0] mode, tx_data, got_data, last_d;
   logic out_pin, out_oe, tx_busy, tx_irq, tx_flag, rx_done, rx_err, rx_busy, line;
   logic [7:0] rx_buf, rx_st;
   logic err_prev = 1'b0, chk_done = 1'b0, unread = 1'b0;
   int errors = 0, num_checks = 0, seed = 90543;
   logic [31:0] r;
   note_s rxq[$], cur;
   logic [7:0] txq[$];
   async_serial_tx_rx_core #(.BIT_TICKS(BT)) u_async_serial_tx_rx_core (
      .CLK_IN(clk), .RST_IN(rst), .SERIAL_MODE_REG_IN(mode), .BAUD_DIVIDER_REG_IN(8'h00),
      .TX_WRITE_IN(tx_write), .TX_DATA_IN(tx_data), .TX_FLAG_CLR_IN(flag_clr),
      .RX_BUF_READ_IN(buf_read), .SERIAL_IN_PIN_IN(line), .EXT_CLK_SEL_IN(ext_sel),
      .LOW_POWER_IN(low_pw), .SERIAL_OUT_PIN_OUT(out_pin), .SERIAL_OUT_OE_OUT(out_oe),
      .TX_BUSY_OUT(tx_busy), .TX_DONE_IRQ_OUT(tx_irq), .TX_DONE_PENDING_FLAG_OUT(tx_flag),
      .RX_BUFFER_REG_OUT(rx_buf), .RX_ERROR_STATUS_REG_OUT(rx_st), .RX_DONE_IRQ_OUT(rx_done),
      .RX_ERROR_IRQ_OUT(rx_err), .RX_BUSY_OUT(rx_busy));
   serial_station #(.BT(BT)) u_serial_station (.clk_in(clk), .line_in(out_pin), .mode_in(mode),
      .line_out(line), .got_out(got), .got_data_out(got_data), .got_ok_out(got_ok));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up;
      $display("Checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         errors++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic set_mode(input logic [1:0] par, input logic cl8, input logic sl2,
                           input logic isrm);
      mode = {1'b1, 1'b1, par, cl8, sl2, isrm, 1'b0};
      tick(1);
   endtask : set_mode
   task automatic pulse_read;
      buf_read = 1'b1;
      tick(1);
      buf_read = 1'b0;
      tick(1);
      chk(rx_st === `ERR_NONE, "status after read");
      unread = 1'b0;
   endtask : pulse_read
   // ----------------------------------------
   // Drivers with expectation notes
   // ----------------------------------------
   task automatic rx_frame(input logic [7:0] d, input logic bp, input logic bs, input logic keep);
      note_s n;
      n.d = d & {mode[3], 7'h7f};
      n.st = (unread ? `ERR_OVR : 8'h00) | (bs ? `ERR_FRM : 8'h00) |
             ((bp && mode[5]) ? `ERR_PAR : 8'h00);
      n.isrm = mode[1];
      rxq.push_back(n);
      last_d = n.d;
      u_serial_station.send(d, bp, bs);
      tick(2 * BT);
      unread = keep;
      if (!keep) begin
         pulse_read();
      end
   endtask : rx_frame
   task automatic tx_frame(input logic [7:0] d);
      int w;
      int bits;
      bits = (mode[3] ? 9 : 8) + (mode[5:4] != PAR_NONE) + (mode[2] ? 2 : 1);
      txq.push_back(d & {mode[3], 7'h7f});
      tx_data = d;
      tx_write = 1'b1;
      tick(1);
      tx_write = 1'b0;
      chk(tx_busy === 1'b1 && out_pin === 1'b0, "start bit");
      w = 0;
      while (tx_busy === 1'b1 && w < 20 * BT) begin
         tick(1);
         w++;
      end
      if (w >= 20 * BT) begin
         errors++;
         wrap_up();
      end
      chk(w == bits * BT, "frame length");
      chk(tx_irq === 1'b1, "tx done irq");
      tick(1);
      chk(tx_flag === 1'b1, "tx flag set");
      flag_clr = 1'b1;
      tick(1);
      flag_clr = 1'b0;
      tick(1);
      chk(tx_flag === 1'b0, "tx flag clear");
   endtask : tx_frame
   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(posedge clk) begin : watch
      logic [7:0] td;
      if (chk_done) begin
         chk(rx_done === !cur.isrm, "done after error");
      end
      chk_done = 1'b0;
      if (rx_err === 1'b1 || (rx_done === 1'b1 && !err_prev)) begin
         if (rxq.size() == 0) begin
            chk(1'b0, "unexpected frame");
         end else begin
            cur = rxq.pop_front();
            chk(rx_buf === cur.d, "rx data");
            chk(rx_st === cur.st, "rx status");
            chk(rx_err === (cur.st != 8'h00), "error irq");
            chk_done = rx_err;
         end
      end
      err_prev = rx_err;
      if (got === 1'b1) begin
         if (txq.size() == 0) begin
            chk(1'b0, "unexpected tx frame");
         end else begin
            td = txq.pop_front();
            chk(got_data === td && got_ok === 1'b1, "tx frame");
         end
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst, tx_write, flag_clr, buf_read, ext_sel, low_pw} = 6'h21;
      {low_pw} = 1'b0;
      mode = 8'h00;
      tx_data = 8'h00;
      last_d = 8'h00;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      set_mode(PAR_NONE, 1'b1, 1'b0, 1'b0);
      chk(out_oe === 1'b1 && out_pin === 1'b1, "idle high");
      for (int i = 0; i < 24; i++) begin
         r = $random(seed);
         set_mode(r[1:0], r[2], r[3], r[4]);
         fork
            tx_frame(r[23:16]);
            rx_frame(r[15:8], r[5], 1'b0, 1'b0);
         join
      end
      for (int i = 0; i < 2; i++) begin
         set_mode(PAR_ODD, 1'b1, 1'b0, i[0]);
         rx_frame(8'ha5, 1'b0, 1'b1, 1'b0);
      end
      set_mode(PAR_EVEN, 1'b1, 1'b1, 1'b0);
      rx_frame(8'hc3, 1'b1, 1'b0, 1'b1);
      rx_frame(8'h3c, 1'b0, 1'b0, 1'b0);
      u_serial_station.bit_out(1'b0, BT / 4);
      u_serial_station.bit_out(1'b1, BT);
      tick(2 * BT);
      fork
         u_serial_station.send(8'h00, 1'b0, 1'b0);
         begin
            tick(3 * BT);
            mode[6] = 1'b0;
            tick(1);
            chk(rx_busy === 1'b0, "abort at once");
         end
      join
      mode[6] = 1'b1;
      tick(2);
      chk(rx_buf === last_d && rx_st === `ERR_NONE, "abort keeps buffer");
      ext_sel = 1'b1;
      low_pw = 1'b1;
      rx_frame(8'h5a, 1'b1, 1'b0, 1'b1);
      chk(rxq.size() == 1, "irq held in low power");
      low_pw = 1'b0;
      tick(4);
      pulse_read();
      ext_sel = 1'b0;
      tick(4 * BT);
      chk(rxq.size() == 0 && txq.size() == 0, "all results seen");
      wrap_up();
   end
endmodule : testbench
